// ==== bafsm_consts.vh ====
// Constants for the burner alarm and shutdown supervisor
`ifndef BAFSM_CONSTS_VH
`define BAFSM_CONSTS_VH
`define BAFSM_ADDR_CTRL 12'h000
`define BAFSM_ADDR_STATUS 12'h004
`define BAFSM_ADDR_MASK 12'h008
`define BAFSM_ADDR_STATE 12'h00c
`define BAFSM_ADDR_BATT 12'h010
`define BAFSM_ADDR_PEND 12'h014
`define BAFSM_CTRL_CLEAR 0
`define BAFSM_CTRL_START 1
`define BAFSM_CTRL_OK 2
`define BAFSM_MASK_RST 6'h00
`define BAFSM_BATT_LOW_RST 12'h0a0
`define BAFSM_BATT_OK_RST 12'h0b0
`define BAFSM_STATE_W 12
`define BAFSM_HOLD_TIME_MS 1000
`define BAFSM_CLK_KHZ 50000
`define BAFSM_HOLD_CYC (`BAFSM_HOLD_TIME_MS * `BAFSM_CLK_KHZ)
`define BAFSM_LINK_TIME_MS 500
`define BAFSM_LINK_CYC (`BAFSM_LINK_TIME_MS * `BAFSM_CLK_KHZ)
`endif

// ==== bafsm_field.sv ====
// Field-side model: safety module reports and pilot flame
`timescale 1ns/1ps
module bafsm_field #(
  parameter PERIOD = 10
) (
  input wire pclk,
  input wire presetn,
  input wire alive,
  input wire pilot_valve_q,
  output reg bsm_report,
  output reg flame_detected
);
  reg [7:0] cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 8'h00;
      bsm_report <= 1'b0;
      flame_detected <= 1'b0;
    end else begin
      cnt_q <= (cnt_q == PERIOD - 1) ? 8'h00 : cnt_q + 8'h01;
      // A dead module stops toggling its report line
      bsm_report <= alive && (cnt_q < PERIOD / 2);
      flame_detected <= pilot_valve_q;
    end
  end
endmodule

// ==== bafsm_monitor.sv ====
// Port checker for the burner alarm and shutdown supervisor
`timescale 1ns/1ps
module bafsm_monitor #(
  parameter HOLD_CYC = 20,
  parameter LINK_CYC = 50
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire permissive_in,
  input wire start_keys_n,
  input wire bsm_lockout,
  input wire bsm_report,
  input wire [2:0] process_valve_q,
  input wire pilot_valve_q,
  input wire main_valve_q,
  input wire alarm_out_q
);
  // ****
  // Helper counters
  // ****
  reg [31:0] keys_q;
  reg [31:0] gap_q;
  reg rep_q;
  wire safe = alarm_out_q && !pilot_valve_q && !main_valve_q && process_valve_q == 3'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      keys_q <= 32'h0;
      gap_q <= 32'h0;
      rep_q <= 1'b0;
    end else begin
      keys_q <= start_keys_n ? 32'h0 : keys_q + 32'h1;
      gap_q <= (bsm_report && !rep_q) ? 32'h0 : gap_q + 32'h1;
      rep_q <= bsm_report;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_RST_SAFE: assert property ($rose(presetn) |-> safe) else $error("unsafe after reset");
  AST_PREADY: assert property (psel && penable |-> pready) else $error("no ready");
  AST_SLVERR: assert property (psel && penable && paddr > 12'h014 |-> pslverr)
    else $error("no error on unmapped");
  AST_MAPPED: assert property (psel && penable && paddr <= 12'h014 && paddr[1:0] == 2'h0
    |-> !pslverr) else $error("error on mapped");
  AST_PERM: assert property (permissive_in [*3] |-> ##[1:6] safe)
    else $error("permissive alarm missing");
  AST_LOCK: assert property (bsm_lockout [*3] |-> ##[1:6] safe)
    else $error("lockout alarm missing");
  AST_LINK: assert property (gap_q > LINK_CYC + 8 |-> safe) else $error("link loss missed");
  AST_START: assert property ($fell(alarm_out_q) |-> keys_q >= HOLD_CYC)
    else $error("left stop early");
  AST_PILOT: assert property ($rose(pilot_valve_q) |-> keys_q >= HOLD_CYC)
    else $error("pilot opened early");
endmodule
bind bafsm_top bafsm_monitor #(.HOLD_CYC(HOLD_CYC), .LINK_CYC(LINK_CYC)) u_mon (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .permissive_in(permissive_in),
  .start_keys_n(start_keys_n), .bsm_lockout(bsm_lockout), .bsm_report(bsm_report),
  .process_valve_q(process_valve_q), .pilot_valve_q(pilot_valve_q),
  .main_valve_q(main_valve_q), .alarm_out_q(alarm_out_q));

// ==== bafsm_sync.v ====
// Two-flop synchroniser for one external level
`timescale 1ns/1ps
module bafsm_sync (
  input wire pclk,
  input wire presetn,
  input wire d,
  output reg q
);
  reg meta_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ==== bafsm_top.v ====
// Burner alarm and shutdown supervisor with APB registers
`timescale 1ns/1ps
`include "bafsm_consts.vh"
module bafsm_top #(
  parameter HOLD_CYC = `BAFSM_HOLD_CYC,
  parameter LINK_CYC = `BAFSM_LINK_CYC
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire closure_proof_input,
  input wire permissive_in,
  input wire [11:0] battery_level,
  input wire start_keys_n,
  input wire flame_detected,
  input wire pilot_retries_done,
  input wire shutdown_cond,
  input wire [2:0] process_demand,
  input wire [2:0] process_lit,
  input wire purge_done,
  input wire bsm_lockout,
  input wire bsm_report,
  output reg [2:0] process_valve_q,
  output reg pilot_valve_q,
  output reg main_valve_q,
  output reg indep_valve_q,
  input wire indep_demand,
  output reg alarm_out_q,
  output wire irq
);
  // ************************************************************
  // Input synchronisers
  // ************************************************************
  localparam NSYNC = 11;
  wire [NSYNC-1:0] raw_in;
  wire [NSYNC-1:0] syn;
  assign raw_in = {closure_proof_input, permissive_in, ~start_keys_n, flame_detected,
                   pilot_retries_done, shutdown_cond, purge_done, bsm_lockout,
                   bsm_report, indep_demand, |process_demand};
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
      bafsm_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .d(raw_in[gi]),
        .q(syn[gi])
      );
    end
  endgenerate
  wire s_poc = syn[10];
  wire s_perm = syn[9];
  wire s_keys = syn[8];
  wire s_flame = syn[7];
  wire s_retry_done = syn[6];
  wire s_shut = syn[5];
  wire s_purged = syn[4];
  wire s_lock = syn[3];
  wire s_rep = syn[2];
  wire s_indep = syn[1];
  wire s_demand = syn[0];
  reg [2:0] dem_m_q;
  reg [2:0] dem_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dem_m_q <= 3'h0;
      dem_q <= 3'h0;
    end else begin
      dem_m_q <= process_demand;
      dem_q <= dem_m_q;
    end
  end
  // Battery words are sampled twice; the value is assumed slow moving
  reg [11:0] batt_m_q;
  reg [11:0] batt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      batt_m_q <= 12'hfff;
      batt_q <= 12'hfff;
    end else begin
      batt_m_q <= battery_level;
      batt_q <= batt_m_q;
    end
  end

  // ************************************************************
  // States
  // ************************************************************
  localparam [11:0] ST_STOPPED = 12'h001;
  localparam [11:0] ST_STARTUP = 12'h002;
  localparam [11:0] ST_PURGE = 12'h004;
  localparam [11:0] ST_IGNITE = 12'h008;
  localparam [11:0] ST_IDLE = 12'h010;
  localparam [11:0] ST_PILOT = 12'h020;
  localparam [11:0] ST_ACTIVE = 12'h040;
  localparam [11:0] ST_SHUTDOWN = 12'h080;
  localparam [11:0] ST_ALARM = 12'h100;
  reg [11:0] state_q;
  reg [11:0] state_d;

  // ************************************************************
  // Register file
  // ************************************************************
  reg [5:0] mask_q;
  reg [5:0] stat_q;
  reg [11:0] batt_low_q;
  reg [11:0] batt_ok_q;
  reg clear_q;
  wire wr = psel & penable & pwrite;
  wire rd = psel & penable & ~pwrite;
  assign pready = 1'b1;
  wire mapped = (paddr == `BAFSM_ADDR_CTRL) || (paddr == `BAFSM_ADDR_STATUS) ||
                (paddr == `BAFSM_ADDR_MASK) || (paddr == `BAFSM_ADDR_STATE) ||
                (paddr == `BAFSM_ADDR_BATT) || (paddr == `BAFSM_ADDR_PEND);
  assign pslverr = psel & penable & ~mapped;
  wire clear_cmd = clear_q;
  wire ctrl_wr = wr && (paddr == `BAFSM_ADDR_CTRL);
  wire sw_start = ctrl_wr && pwdata[`BAFSM_CTRL_START];
  wire sw_ok = ctrl_wr && pwdata[`BAFSM_CTRL_OK];

  // ************************************************************
  // Pending alarms
  // ************************************************************
  // Bits: 0 pilot fail, 1 closure proof, 2 battery, 3 permissive, 4 module, 5 shutdown
  reg [5:0] pend_q;
  reg [5:0] pend_d;
  reg [5:0] cause;
  reg [5:0] evt;
  reg [25:0] link_cnt_q;
  wire link_lost = (link_cnt_q >= LINK_CYC[25:0]);
  reg rep_q;
  wire rep_edge = s_rep & ~rep_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_cnt_q <= 26'h0000000;
      rep_q <= 1'b0;
    end else begin
      rep_q <= s_rep;
      if (rep_edge) begin
        link_cnt_q <= 26'h0000000;
      end else if (!link_lost) begin
        link_cnt_q <= link_cnt_q + 26'h0000001;
      end
    end
  end
  wire batt_low = (batt_q <= batt_low_q);
  wire batt_ok = (batt_q >= batt_ok_q);
  wire in_run = (state_q == ST_IDLE) || (state_q == ST_PILOT) || (state_q == ST_ACTIVE);
  wire ign_fail = (state_q == ST_IGNITE) && s_retry_done && !s_flame;
  always @* begin
    evt = 6'h00;
    evt[0] = ign_fail;
    evt[1] = (state_q == ST_STARTUP) && s_poc;
    evt[2] = batt_low;
    evt[3] = s_perm;
    evt[4] = s_lock | link_lost;
    evt[5] = in_run && s_shut;
    cause = 6'h00;
    cause[2] = ~batt_ok;
    cause[3] = s_perm;
    cause[4] = s_lock | link_lost;
    // Set wins over clear, and a live battery, permissive or module cause keeps its bit pending
    pend_d = pend_q;
    if (clear_cmd) begin
      pend_d = pend_q & cause;
    end
    pend_d = pend_d | evt;
  end

  // ************************************************************
  // Start key hold timer
  // ************************************************************
  reg [25:0] hold_cnt_q;
  wire hold_done = (hold_cnt_q >= HOLD_CYC[25:0]);
  wire keys = s_keys | sw_start;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_cnt_q <= 26'h0000000;
    end else if (!keys) begin
      hold_cnt_q <= 26'h0000000;
    end else if (!hold_done) begin
      hold_cnt_q <= hold_cnt_q + 26'h0000001;
    end
  end

  // ************************************************************
  // Supervisor state machine
  // ************************************************************
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_STOPPED: begin
        if (hold_done) begin
          state_d = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (!keys) begin
          state_d = ST_STOPPED;
        end else begin
          state_d = ST_PURGE;
        end
      end
      ST_PURGE: begin
        if (!keys) begin
          state_d = ST_STOPPED;
        end else if (s_purged) begin
          state_d = ST_IGNITE;
        end
      end
      ST_IGNITE: begin
        if (s_flame) begin
          state_d = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (sw_ok) begin
          state_d = ST_PILOT;
        end
      end
      ST_PILOT: begin
        if (!s_flame) begin
          state_d = ST_STOPPED;
        end else if (s_demand) begin
          state_d = ST_ACTIVE;
        end
      end
      ST_ACTIVE: begin
        if (!s_flame) begin
          state_d = ST_STOPPED;
        end else if (!s_demand) begin
          state_d = ST_PILOT;
        end
      end
      ST_SHUTDOWN: begin
        if (pend_d == 6'h00) begin
          state_d = ST_STOPPED;
        end
      end
      ST_ALARM: begin
        if (pend_d == 6'h00) begin
          state_d = ST_STOPPED;
        end
      end
      default: begin
        state_d = ST_STOPPED;
      end
    endcase
    // Alarms outrank shutdowns and every other move
    if (|pend_d[4:0]) begin
      state_d = ST_ALARM;
    end else if (pend_d[5] && state_q != ST_ALARM) begin
      state_d = ST_SHUTDOWN;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_STOPPED;
      pend_q <= 6'h00;
    end else begin
      state_q <= state_d;
      pend_q <= pend_d;
    end
  end

  // ************************************************************
  // Valves and alarm output
  // ************************************************************
  wire safe_off = (state_d == ST_STOPPED) || (state_d == ST_SHUTDOWN) ||
                  (state_d == ST_ALARM) || (state_d == ST_STARTUP) ||
                  (state_d == ST_PURGE);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      process_valve_q <= 3'h0;
      pilot_valve_q <= 1'b0;
      main_valve_q <= 1'b0;
      indep_valve_q <= 1'b0;
      alarm_out_q <= 1'b1;
    end else begin
      // Independent process runs on its own demand, untouched by trips
      indep_valve_q <= s_indep;
      if (safe_off) begin
        process_valve_q <= 3'h0;
        pilot_valve_q <= 1'b0;
        main_valve_q <= 1'b0;
      end else begin
        pilot_valve_q <= 1'b1;
        main_valve_q <= 1'b1;
        process_valve_q <= (state_d == ST_ACTIVE) ? dem_q : 3'h0;
      end
      alarm_out_q <= (state_d == ST_STOPPED) || (state_d == ST_SHUTDOWN) ||
                     (state_d == ST_ALARM);
    end
  end

  // ************************************************************
  // Status, mask and bus writes
  // ************************************************************
  wire stat_rd = rd && (paddr == `BAFSM_ADDR_STATUS);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_q <= `BAFSM_MASK_RST;
      stat_q <= 6'h00;
      batt_low_q <= `BAFSM_BATT_LOW_RST;
      batt_ok_q <= `BAFSM_BATT_OK_RST;
      clear_q <= 1'b0;
    end else begin
      clear_q <= ctrl_wr && pwdata[`BAFSM_CTRL_CLEAR];
      // New events win over the read clear
      stat_q <= (stat_rd ? 6'h00 : stat_q) | (pend_d & ~pend_q);
      if (wr && paddr == `BAFSM_ADDR_MASK) begin
        mask_q <= pwdata[5:0];
      end
      if (wr && paddr == `BAFSM_ADDR_BATT) begin
        batt_low_q <= pwdata[11:0];
        batt_ok_q <= pwdata[27:16];
      end
    end
  end
  assign irq = |(stat_q & mask_q);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `BAFSM_ADDR_STATUS: prdata <= {26'h0000000, stat_q};
        `BAFSM_ADDR_MASK: prdata <= {26'h0000000, mask_q};
        `BAFSM_ADDR_STATE: prdata <= {20'h00000, state_q};
        `BAFSM_ADDR_BATT: prdata <= {4'h0, batt_ok_q, 4'h0, batt_low_q};
        `BAFSM_ADDR_PEND: prdata <= {26'h0000000, pend_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== test_burner_alarm_shutdown_fsm.sv ====
// Self-checking bench for the burner alarm and shutdown supervisor
`timescale 1ns/1ps
`include "bafsm_consts.vh"
module test_burner_alarm_shutdown_fsm;
  reg pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire pready, pslverr, irq, pilot_valve_q, main_valve_q, indep_valve_q, alarm_out_q;
  wire bsm_report, flame_detected;
  wire [2:0] process_valve_q;
  reg permissive_in = 0, start_keys_n = 1, shutdown_cond = 0, purge_done = 0;
  reg bsm_lockout = 0, alive = 1, indep_demand = 0;
  reg closure_proof_input = 0, pilot_retries_done = 0;
  reg [2:0] process_demand = 0;
  reg [11:0] battery_level = 12'h0c0;
  integer seed = 2435, fails = 0, samples_checked = 0, cyc_n = 0, n;
  reg [63:0] rq[$];
  reg [63:0] e;
  always #10 pclk = ~pclk;
  bafsm_top #(.HOLD_CYC(20), .LINK_CYC(50)) dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .closure_proof_input(closure_proof_input),
    .permissive_in(permissive_in), .battery_level(battery_level),
    .start_keys_n(start_keys_n), .flame_detected(flame_detected),
    .pilot_retries_done(pilot_retries_done), .shutdown_cond(shutdown_cond),
    .process_demand(process_demand), .process_lit(3'h0), .purge_done(purge_done),
    .bsm_lockout(bsm_lockout), .bsm_report(bsm_report), .process_valve_q(process_valve_q),
    .pilot_valve_q(pilot_valve_q), .main_valve_q(main_valve_q),
    .indep_valve_q(indep_valve_q), .indep_demand(indep_demand),
    .alarm_out_q(alarm_out_q), .irq(irq));
  bafsm_field u_field (.pclk(pclk), .presetn(presetn), .alive(alive),
    .pilot_valve_q(pilot_valve_q), .bsm_report(bsm_report),
    .flame_detected(flame_detected));
  // ****
  // Checking and closing
  // ****
  task summarize;
    begin
      $display("checks %0d fails %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
        $display("DONE - PASS");
      end else begin
        $display("DONE - FAIL");
      end
      $finish;
    end
  endtask
  task cmp_rd(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        fails = fails + 1;
        $display("BAD rd t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Independent valve must follow its own demand whatever the trip state
  task pin(input [7:0] exp);
    reg [7:0] got;
    begin
      @(negedge pclk);
      got = {indep_valve_q, alarm_out_q, pilot_valve_q, main_valve_q, process_valve_q, irq};
      samples_checked = samples_checked + 1;
      if (got !== {indep_demand, exp[6:0]}) begin
        fails = fails + 1;
        $display("BAD pin t=%0t got=%h exp=%h", $time, got, {indep_demand, exp[6:0]});
      end
      @(posedge pclk);
    end
  endtask
  always @(posedge pclk) begin
    cyc_n <= cyc_n + 1;
    if (psel && penable && pready && !pwrite && rq.size() > 0) begin
      e = rq.pop_front();
      cmp_rd(prdata & e[63:32], e[31:0]);
    end
    if (cyc_n == 20000) begin
      fails = fails + 1;
      summarize;
    end
  end
  // ****
  // Drivers
  // ****
  task wt(input integer c);
    repeat (c) @(posedge pclk);
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
    end
  endtask
  task rd(input [11:0] a, input [31:0] m, input [31:0] x);
    begin
      rq.push_back({m, x});
      apb(1'b0, a, 32'h0);
    end
  endtask
  task clr;
    begin
      apb(1'b1, `BAFSM_ADDR_CTRL, 32'h1);
      wt(2);
    end
  endtask
  task cause(input integer b, input integer l);
    reg [31:0] r;
    begin
      r = $random(seed);
      process_demand <= r[2:0];
      indep_demand <= r[3];
      case (b)
        2: battery_level <= (l == 0) ? 12'h0b0 : (l == 1) ? 12'h0a0 : 12'h0a1 + {9'h0, r[6:4]};
        3: permissive_in <= (l != 0);
        4: bsm_lockout <= (l != 0);
        default: alive <= (l == 0);
      endcase
    end
  endtask
  task cyc(input integer b, input integer k);
    begin
      cause(b, 1);
      wt(80);
      pin(8'h41);
      rd(`BAFSM_ADDR_PEND, 32'h3f, 32'h1 << k);
      rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h100);
      cause(b, 2);
      wt(4);
      clr;
      rd(`BAFSM_ADDR_PEND, 32'h1 << k, 32'h1 << k);
      cause(b, 0);
      wt(30);
      clr;
      rd(`BAFSM_ADDR_PEND, 32'h3f, 32'h0);
      rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h1);
      rd(`BAFSM_ADDR_STATUS, 32'h1 << k, 32'h1 << k);
      rd(`BAFSM_ADDR_STATUS, 32'h3f, 32'h0);
      pin(8'h40);
    end
  endtask
  // Start attempt that trips on closure proof (k=1) or exhausted retries (k=0)
  task fail_start(input integer k);
    begin
      closure_proof_input <= (k == 1);
      pilot_retries_done <= (k == 0);
      start_keys_n <= 1'b0;
      wt(40);
      pin(8'h41);
      rd(`BAFSM_ADDR_PEND, 32'h3f, 32'h1 << k);
      rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h100);
      start_keys_n <= 1'b1;
      wt(40);
      rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h100);
      closure_proof_input <= 1'b0;
      pilot_retries_done <= 1'b0;
      clr;
      rd(`BAFSM_ADDR_PEND, 32'h3f, 32'h0);
      rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h1);
      rd(`BAFSM_ADDR_STATUS, 32'h3f, 32'h1 << k);
      pin(8'h40);
    end
  endtask
  initial begin
    wt(2);
    presetn <= 1'b1;
    wt(1);
    rd(`BAFSM_ADDR_MASK, 32'hffffffff, 32'h0);
    rd(`BAFSM_ADDR_BATT, 32'hffffffff, 32'h00b0_00a0);
    rd(12'h018, 32'hffffffff, 32'h0);
    apb(1'b1, 12'h018, 32'hffffffff);
    apb(1'b1, `BAFSM_ADDR_MASK, 32'h3f);
    rd(`BAFSM_ADDR_MASK, 32'h3f, 32'h3f);
    shutdown_cond <= 1'b1;
    wt(8);
    rd(`BAFSM_ADDR_PEND, 32'h3f, 32'h0);
    rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h1);
    shutdown_cond <= 1'b0;
    purge_done <= 1'b1;
    start_keys_n <= 1'b0;
    n = 0;
    while (pilot_valve_q !== 1'b1 && n < 500) begin
      @(negedge pclk);
      n = n + 1;
    end
    wt(10);
    rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h010);
    process_demand <= 3'h5;
    apb(1'b1, `BAFSM_ADDR_CTRL, 32'h4);
    wt(6);
    pin(8'h3a);
    rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h040);
    start_keys_n <= 1'b1;
    shutdown_cond <= 1'b1;
    wt(8);
    pin(8'h41);
    rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h080);
    rd(`BAFSM_ADDR_PEND, 32'h3f, 32'h20);
    shutdown_cond <= 1'b0;
    wt(4);
    rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h080);
    clr;
    rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h1);
    rd(`BAFSM_ADDR_STATUS, 32'h20, 32'h20);
    apb(1'b1, `BAFSM_ADDR_CTRL, 32'h2);
    wt(4);
    rd(`BAFSM_ADDR_STATE, 32'hfff, 32'h1);
    cyc(2, 2);
    cyc(3, 3);
    cyc(4, 4);
    cyc(5, 4);
    fail_start(1);
    fail_start(0);
    summarize;
  end
endmodule
